// [autoneg_page_registers.sv]
// Behaviour
// - Partner base bit 15 reports next page support.
// - Partner base acknowledge shows page reception.
// - Partner remote fault field shown read only.
// - Partner pause field, reset 00, read only.
// - Partner half and full duplex bits.
// - Expansion next-page-able bit always reads one.
// - Page received flag sets, clears on read.
// - Host-written next page bit, reset zero.
// - Message page bit and code field, host written.
// - Host-written second acknowledge, reset zero.
// - Transmit toggle flips per next page sent.
// - Receive next page, message bit, code field.
// - Receive second acknowledge as received.
// - Receive toggle bit exposed read only.
// - Receive acknowledge shows partner page reception.
// - Extended status top bit reads one.
// - Other extended status bits read zero.
`timescale 1ns/10ps
`default_nettype none
module autoneg_page_registers (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	// Station address strap
	input  wire logic [4:0]  i_phy_addr,
	// Management serial interface
	input  wire logic        i_mdc,
	input  wire logic        i_mdio,
	output logic             o_mdio,
	output logic             o_mdio_oe,
	// Pages received by the negotiation engine
	input  wire logic        i_page_rx_valid,
	input  wire logic        i_page_rx_base,
	input  wire logic [15:0] i_page_rx_word,
	// Next page toward the negotiation engine
	input  wire logic        i_np_tx_sent,
	output logic [15:0]      o_np_tx_word,
	output logic             o_np_tx_written
);

	// Pin synchronisation. The clock and data pins share one synchroniser so
	// that both arrive with the same latency and data is sampled coherently.
	logic [1:0] pins_sync;
	logic       mdc_prev_reg;
	logic [4:0] phy_addr_reg;

	bit_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.i_clk_sys(i_clk_sys),
		.i_arst_n (i_arst_n),
		.i_async  ({i_mdc, i_mdio}),
		.o_sync   (pins_sync)
	);

	wire mdc_s    = pins_sync[1];
	wire mdio_s   = pins_sync[0];
	wire mdc_rise = mdc_s & ~mdc_prev_reg;

	// The strap is caught every cycle after reset rather than under reset, so
	// that the asynchronous reset only ever loads a constant.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mdc_prev_reg <= 1'b0;
			phy_addr_reg <= 5'h00;
		end else begin
			mdc_prev_reg <= mdc_s;
			phy_addr_reg <= i_phy_addr;
		end
	end

	// Captured partner pages.
	page_if pages ();

	page_capture u_capture (
		.i_clk_sys   (i_clk_sys),
		.i_arst_n    (i_arst_n),
		.i_page_valid(i_page_rx_valid),
		.i_page_base (i_page_rx_base),
		.i_page_word (i_page_rx_word),
		.pages       (pages)
	);

	// Transmit next page fields.
	logic        np_tx_np_reg;
	logic        np_tx_mp_reg;
	logic        np_tx_ack2_reg;
	logic        np_tx_tgl_reg;
	logic [10:0] np_tx_code_reg;
	logic        np_tx_written_reg;

	wire [15:0] np_tx_word = {np_tx_np_reg, 1'b0, np_tx_mp_reg, np_tx_ack2_reg,
		np_tx_tgl_reg, np_tx_code_reg};

	wire [15:0] expansion_word = {13'h0000, 1'b1, pages.page_rcvd, 1'b0};

	// Partner base word as the host sees it. The capture already cleared the
	// reserved bits, so only the named flags are picked out here.
	wire        base_np    = pages.base_reg[an_page_pkg::BIT_NEXT_PAGE];
	wire        base_ack   = pages.base_reg[an_page_pkg::BIT_ACK];
	wire [13:0] base_rest  = pages.base_reg[an_page_pkg::BIT_MSG_PAGE:an_page_pkg::CODE_LO];
	wire [15:0] base_word  = {base_np, base_ack, base_rest};

	// Receive next page fields, passed through exactly as the partner sent
	// them. Nothing here interprets the code; software reads it by the
	// message page bit.
	wire        rx_np      = pages.np_rx_reg[an_page_pkg::BIT_NEXT_PAGE];
	wire        rx_ack     = pages.np_rx_reg[an_page_pkg::BIT_ACK];
	wire        rx_mp      = pages.np_rx_reg[an_page_pkg::BIT_MSG_PAGE];
	wire        rx_ack2    = pages.np_rx_reg[an_page_pkg::BIT_ACK2];
	wire        rx_tgl     = pages.np_rx_reg[an_page_pkg::BIT_TOGGLE];
	wire [10:0] rx_code    = pages.np_rx_reg[an_page_pkg::CODE_HI:an_page_pkg::CODE_LO];
	wire [15:0] np_rx_word = {rx_np, rx_ack, rx_mp, rx_ack2, rx_tgl, rx_code};

	// Frame bit counter step, shared by every state that counts bits.
	function automatic logic [3:0] count_up(input logic [3:0] cnt);
		return cnt + an_page_pkg::CNT_ONE;
	endfunction

	// Register read decode; addresses without a register here return zero.
	function automatic logic [15:0] reg_read(
		input logic [4:0]  addr,
		input logic [15:0] base_w,
		input logic [15:0] exp_w,
		input logic [15:0] tx_w,
		input logic [15:0] rx_w
	);
		logic [15:0] value;
		value = an_page_pkg::ZERO_WORD;
		case (addr)
			an_page_pkg::REG_PARTNER_BASE: value = base_w;
			an_page_pkg::REG_EXPANSION:    value = exp_w;
			an_page_pkg::REG_NP_TRANSMIT:  value = tx_w;
			an_page_pkg::REG_NP_RECEIVE:   value = rx_w;
			an_page_pkg::REG_EXT_STATUS:   value = an_page_pkg::EXT_STATUS_WORD;
			default:                       value = an_page_pkg::ZERO_WORD;
		endcase
		return value;
	endfunction

	// Frame engine state.
	an_page_pkg::mdio_state_e state_reg;
	an_page_pkg::mdio_state_e state_next;
	logic [3:0]  cnt_reg;
	logic [3:0]  cnt_next;
	logic [12:0] hdr_reg;
	logic [12:0] hdr_next;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic        mine_reg;
	logic        mine_next;
	logic        rd_reg;
	logic        rd_next;
	logic [4:0]  addr_reg;
	logic [4:0]  addr_next;
	logic        mdio_out_reg;
	logic        mdio_out_next;
	logic        mdio_oe_reg;
	logic        mdio_oe_next;

	// Header fields as they complete with the bit now arriving.
	wire [12:0] hdr_full   = {hdr_reg[11:0], mdio_s};
	wire        hdr_start  = hdr_full[12];
	wire [1:0]  hdr_op     = hdr_full[11:10];
	wire [4:0]  hdr_phy    = hdr_full[9:5];
	wire [4:0]  hdr_reg_ad = hdr_full[4:0];
	wire        hdr_ok     = (hdr_start == an_page_pkg::START_SECOND) &&
		((hdr_op == an_page_pkg::OP_READ) || (hdr_op == an_page_pkg::OP_WRITE));
	wire        hdr_mine   = hdr_ok && (hdr_phy == phy_addr_reg);
	wire        hdr_rd     = (hdr_op == an_page_pkg::OP_READ);
	wire        hdr_done   = mdc_rise && (state_reg == an_page_pkg::MDIO_HDR) &&
		(cnt_reg == an_page_pkg::HDR_LAST);
	// The read value is snapshot at the end of the header, so a page that
	// arrives while the data bits are shifted out cannot tear the word.
	wire [15:0] rd_value   = reg_read(hdr_reg_ad, base_word, expansion_word,
		np_tx_word, np_rx_word);
	wire [15:0] wr_value   = {shift_reg[14:0], mdio_s};
	wire        wr_done    = mdc_rise && (state_reg == an_page_pkg::MDIO_DATA) &&
		(cnt_reg == an_page_pkg::DATA_LAST) && mine_reg && !rd_reg;
	wire        wr_np_tx   = wr_done && (addr_reg == an_page_pkg::REG_NP_TRANSMIT);

	// The flag clears when its value is captured for a read, so a page that
	// lands later in the same frame stays visible to the next read.
	assign pages.clr_page_rcvd = hdr_done && hdr_mine && hdr_rd &&
		(hdr_reg_ad == an_page_pkg::REG_EXPANSION);

	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		hdr_next      = hdr_reg;
		shift_next    = shift_reg;
		mine_next     = mine_reg;
		rd_next       = rd_reg;
		addr_next     = addr_reg;
		mdio_out_next = mdio_out_reg;
		mdio_oe_next  = mdio_oe_reg;
		if (mdc_rise) begin
			case (state_reg)
				an_page_pkg::MDIO_IDLE: begin
					// Preamble ones are optional; the first zero starts a frame.
					if (!mdio_s) begin
						state_next = an_page_pkg::MDIO_HDR;
						cnt_next   = an_page_pkg::CNT_ZERO;
					end
				end
				an_page_pkg::MDIO_HDR: begin
					hdr_next = hdr_full;
					if (cnt_reg == an_page_pkg::HDR_LAST) begin
						state_next = an_page_pkg::MDIO_TA;
						cnt_next   = an_page_pkg::CNT_ZERO;
						mine_next  = hdr_mine;
						rd_next    = hdr_rd;
						addr_next  = hdr_reg_ad;
						shift_next = rd_value;
					end else begin
						cnt_next = count_up(cnt_reg);
					end
				end
				// The first turnaround bit is left to the host; the block only
				// takes the line from the second one, so two drivers never meet.
				an_page_pkg::MDIO_TA: begin
					if (cnt_reg == an_page_pkg::TA_LAST) begin
						state_next = an_page_pkg::MDIO_DATA;
						cnt_next   = an_page_pkg::CNT_ZERO;
						if (mine_reg && rd_reg) begin
							mdio_out_next = shift_reg[15];
							shift_next    = {shift_reg[14:0], 1'b0};
						end
					end else begin
						cnt_next = count_up(cnt_reg);
						// Second turnaround bit is driven low on a read.
						if (mine_reg && rd_reg) begin
							mdio_oe_next  = 1'b1;
							mdio_out_next = 1'b0;
						end
					end
				end
				an_page_pkg::MDIO_DATA: begin
					if (mine_reg && rd_reg) begin
						mdio_out_next = shift_reg[15];
						shift_next    = {shift_reg[14:0], 1'b0};
					end else begin
						shift_next = wr_value;
					end
					if (cnt_reg == an_page_pkg::DATA_LAST) begin
						state_next   = an_page_pkg::MDIO_IDLE;
						cnt_next     = an_page_pkg::CNT_ZERO;
						mdio_oe_next = 1'b0;
						mine_next    = 1'b0;
					end else begin
						cnt_next = count_up(cnt_reg);
					end
				end
				// An illegal state drops the line and waits for a fresh frame.
				default: begin
					state_next   = an_page_pkg::MDIO_IDLE;
					cnt_next     = an_page_pkg::CNT_ZERO;
					mdio_oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg    <= an_page_pkg::MDIO_IDLE;
			cnt_reg      <= an_page_pkg::CNT_ZERO;
			hdr_reg      <= 13'h0000;
			shift_reg    <= an_page_pkg::ZERO_WORD;
			mine_reg     <= 1'b0;
			rd_reg       <= 1'b0;
			addr_reg     <= 5'h00;
			mdio_out_reg <= 1'b0;
			mdio_oe_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			hdr_reg      <= hdr_next;
			shift_reg    <= shift_next;
			mine_reg     <= mine_next;
			rd_reg       <= rd_next;
			addr_reg     <= addr_next;
			mdio_out_reg <= mdio_out_next;
			mdio_oe_reg  <= mdio_oe_next;
		end
	end

	// Transmit next page register. Only the writable fields take the write;
	// the toggle and the reserved bit ignore it.
	wire [15:0] np_wr = wr_value & an_page_pkg::NP_TX_WR_MASK;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			np_tx_np_reg      <= an_page_pkg::NP_TX_NP_RST;
			np_tx_mp_reg      <= an_page_pkg::NP_TX_MP_RST;
			np_tx_ack2_reg    <= an_page_pkg::NP_TX_ACK2_RST;
			np_tx_code_reg    <= an_page_pkg::NP_TX_CODE_RST;
			np_tx_written_reg <= 1'b0;
		end else begin
			np_tx_written_reg <= wr_np_tx;
			if (wr_np_tx) begin
				np_tx_np_reg   <= np_wr[an_page_pkg::BIT_NEXT_PAGE];
				np_tx_mp_reg   <= np_wr[an_page_pkg::BIT_MSG_PAGE];
				np_tx_ack2_reg <= np_wr[an_page_pkg::BIT_ACK2];
				np_tx_code_reg <= np_wr[an_page_pkg::CODE_HI:an_page_pkg::CODE_LO];
			end
		end
	end

	// The toggle advances once per next page handed to the link, so the
	// engine always sends the opposite value from the page before.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n)
			np_tx_tgl_reg <= an_page_pkg::NP_TX_TGL_RST;
		else if (i_np_tx_sent)
			np_tx_tgl_reg <= ~np_tx_tgl_reg;
	end

	assign o_mdio          = mdio_out_reg;
	assign o_mdio_oe       = mdio_oe_reg;
	assign o_np_tx_word    = np_tx_word;
	assign o_np_tx_written = np_tx_written_reg;

endmodule
`default_nettype wire

// [an_page_pkg.sv]
`default_nettype none
package an_page_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int CODE_W = 11;

	// Register addresses on the management serial interface.
	localparam logic [4:0] REG_PARTNER_BASE = 5'h05;
	localparam logic [4:0] REG_EXPANSION    = 5'h06;
	localparam logic [4:0] REG_NP_TRANSMIT  = 5'h07;
	localparam logic [4:0] REG_NP_RECEIVE   = 5'h08;
	localparam logic [4:0] REG_EXT_STATUS   = 5'h0F;

	// Field positions shared by the page registers.
	localparam int BIT_NEXT_PAGE = 15;
	localparam int BIT_ACK       = 14;
	localparam int BIT_MSG_PAGE  = 13;
	localparam int BIT_ACK2      = 12;
	localparam int BIT_TOGGLE    = 11;
	localparam int CODE_HI       = 10;
	localparam int CODE_LO       = 0;
	localparam int EXP_NP_ABLE   = 2;
	localparam int EXP_PAGE_RCVD = 1;

	// Bits of the partner base word that are kept; the rest read zero.
	localparam logic [15:0] BASE_KEEP_MASK  = 16'hF1E0;
	localparam logic [15:0] NP_RX_KEEP_MASK = 16'hFFFF;
	localparam logic [15:0] NP_TX_WR_MASK   = 16'hB7FF;
	localparam logic [15:0] EXT_STATUS_WORD = 16'h8000;
	localparam logic [15:0] ZERO_WORD       = 16'h0000;

	// Reset values of the transmit next page fields.
	localparam logic        NP_TX_NP_RST   = 1'b0;
	localparam logic        NP_TX_MP_RST   = 1'b1;
	localparam logic        NP_TX_ACK2_RST = 1'b0;
	localparam logic        NP_TX_TGL_RST  = 1'b0;
	localparam logic [10:0] NP_TX_CODE_RST = 11'h001;

	// Management frame layout.
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic       START_SECOND  = 1'b1;
	localparam logic [3:0] HDR_LAST      = 4'hC;
	localparam logic [3:0] TA_LAST       = 4'h1;
	localparam logic [3:0] DATA_LAST     = 4'hF;
	localparam logic [3:0] CNT_ZERO      = 4'h0;
	localparam logic [3:0] CNT_ONE       = 4'h1;

	typedef enum logic [1:0] {
		MDIO_IDLE = 2'h0,
		MDIO_HDR  = 2'h1,
		MDIO_TA   = 2'h3,
		MDIO_DATA = 2'h2
	} mdio_state_e;

endpackage
`default_nettype wire

// [page_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface page_if;
	logic [15:0] base_reg;
	logic [15:0] np_rx_reg;
	logic        page_rcvd;
	logic        clr_page_rcvd;

	modport capture (
		output base_reg,
		output np_rx_reg,
		output page_rcvd,
		input  clr_page_rcvd
	);

	modport host (
		input  base_reg,
		input  np_rx_reg,
		input  page_rcvd,
		output clr_page_rcvd
	);
endinterface
`default_nettype wire

// [bit_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_arst_n,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule
`default_nettype wire

// [page_capture.sv]
`timescale 1ns/10ps
`default_nettype none
module page_capture (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	// Pages from the negotiation engine
	input  wire logic        i_page_valid,
	input  wire logic        i_page_base,
	input  wire logic [15:0] i_page_word,
	// Captured pages toward the register file
	page_if.capture          pages
);
	logic [15:0] base_reg;
	logic [15:0] np_rx_reg;
	logic        page_rcvd_reg;
	wire         take_base = i_page_valid & i_page_base;
	wire         take_np   = i_page_valid & ~i_page_base;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			base_reg      <= an_page_pkg::ZERO_WORD;
			np_rx_reg     <= an_page_pkg::ZERO_WORD;
			page_rcvd_reg <= 1'b0;
		end else begin
			if (take_base)
				base_reg <= i_page_word & an_page_pkg::BASE_KEEP_MASK;
			if (take_np)
				np_rx_reg <= i_page_word & an_page_pkg::NP_RX_KEEP_MASK;
			// A page landing in the same cycle as the read-clear must not be lost.
			if (i_page_valid)
				page_rcvd_reg <= 1'b1;
			else if (pages.clr_page_rcvd)
				page_rcvd_reg <= 1'b0;
		end
	end

	assign pages.base_reg  = base_reg;
	assign pages.np_rx_reg = np_rx_reg;
	assign pages.page_rcvd = page_rcvd_reg;
endmodule
`default_nettype wire

// [autoneg_page_registers_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module autoneg_page_registers_asserts (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	// Watched ports
	input  wire logic        i_np_tx_sent,
	input  wire logic        o_mdio,
	input  wire logic        o_mdio_oe,
	input  wire logic [15:0] o_np_tx_word,
	input  wire logic        o_np_tx_written
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_arst_n);

	sequence drive_start_s;
		$rose(o_mdio_oe);
	endsequence
	// The turnaround zero must stand for eight system clocks once the line is taken.
	sequence ta_zero_s;
		(o_mdio_oe && !o_mdio) [*8];
	endsequence

	ta_drive_a: assert property (drive_start_s |-> ta_zero_s)
		else $error("turnaround not driven low");
	read_span_a: assert property ($fell(o_mdio_oe) |-> $past(o_mdio_oe, 100))
		else $error("read answer released too early");
	tx_reserved_a: assert property (!o_np_tx_word[14])
		else $error("transmit page reserved bit set");
	toggle_flip_a: assert property (i_np_tx_sent |=> o_np_tx_word[11] != $past(o_np_tx_word[11]))
		else $error("toggle did not flip");
	toggle_hold_a: assert property (!i_np_tx_sent |=> $stable(o_np_tx_word[11]))
		else $error("toggle moved without a sent page");
	written_pulse_a: assert property (o_np_tx_written |=> !o_np_tx_written)
		else $error("write pulse longer than one cycle");
	// The written fields and the pulse both update on the edge that lands the write.
	write_marked_a: assert property ($changed(o_np_tx_word & 16'hF7FF) |-> o_np_tx_written)
		else $error("transmit word changed without write pulse");
	reset_word_a: assert property ($rose(i_arst_n) |-> o_np_tx_word == 16'h2001)
		else $error("transmit word reset value wrong");
endmodule

bind autoneg_page_registers autoneg_page_registers_asserts u_autoneg_page_registers_asserts (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_np_tx_sent(i_np_tx_sent),
	.o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_np_tx_word(o_np_tx_word),
	.o_np_tx_written(o_np_tx_written)
);
`default_nettype wire

// [mgmt_host.sv]
`timescale 1ns/10ps
`default_nettype none
module mgmt_host (
	// Clock and the resolved data line
	input  wire logic i_clk_sys,
	input  wire logic i_mdio,
	// Drive toward the line
	output logic      o_mdc,
	output logic      o_drv_en,
	output logic      o_drv_val
);
	initial begin
		o_mdc = 1'b1;
		o_drv_en = 1'b0;
		o_drv_val = 1'b1;
	end

	// The management clock idles high between frames and each phase lasts five clocks.
	task automatic frame(input logic wr, input logic [4:0] pa, ra, input logic [15:0] wd,
			output logic [15:0] rd);
		logic [33:0] f;
		f = {4'b1101, wr ? 2'b01 : 2'b10, pa, ra, wr ? 2'b10 : 2'b11, wd};
		for (int i = 33; i >= 0; i--) begin
			@(posedge i_clk_sys);
			o_mdc <= 1'b0;
			// A read hands the line over from the turnaround onward.
			o_drv_en <= wr || i > 17;
			o_drv_val <= f[i];
			repeat (5) @(posedge i_clk_sys);
			if (i < 16) rd[i] = i_mdio;
			o_mdc <= 1'b1;
			repeat (4) @(posedge i_clk_sys);
		end
		o_drv_en <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [autoneg_page_registers_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module autoneg_page_registers_tb_top;
	localparam logic [4:0] PHY = 5'h0B;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        mdc, drv_en, drv_val, dut_mdio, dut_oe, np_written;
	logic        pg_valid = 1'b0;
	logic        pg_base = 1'b0;
	logic [15:0] pg_word = 16'h0000;
	logic        np_sent = 1'b0;
	logic [15:0] np_word, rdata;
	int          fails = 0;
	int          num_checks = 0;
	wire logic   mdio_wire;

	// The line has a pull-up, so it reads one whenever nobody drives it.
	assign mdio_wire = dut_oe ? dut_mdio : (drv_en ? drv_val : 1'b1);

	always #10 clk_sys = ~clk_sys;

	autoneg_page_registers u_autoneg_page_registers (
		.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_phy_addr(PHY), .i_mdc(mdc),
		.i_mdio(mdio_wire), .o_mdio(dut_mdio), .o_mdio_oe(dut_oe),
		.i_page_rx_valid(pg_valid), .i_page_rx_base(pg_base), .i_page_rx_word(pg_word),
		.i_np_tx_sent(np_sent), .o_np_tx_word(np_word), .o_np_tx_written(np_written)
	);

	mgmt_host u_mgmt_host (
		.i_clk_sys(clk_sys), .i_mdio(mdio_wire), .o_mdc(mdc), .o_drv_en(drv_en),
		.o_drv_val(drv_val)
	);

	task automatic end_sim();
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
		u_mgmt_host.frame(1'b0, PHY, ra, 16'h0000, rdata);
		chk($sformatf("reg %h", ra), rdata, exp);
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		u_mgmt_host.frame(1'b1, PHY, ra, d, rdata);
	endtask

	task automatic page(input logic base, input logic [15:0] w);
		pg_valid <= 1'b1;
		pg_base <= base;
		pg_word <= w;
		@(posedge clk_sys);
		pg_valid <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic t_defaults();
		chk("tx word", np_word, 16'h2001);
		rd_chk(5'h05, 16'h0000);
		rd_chk(5'h06, 16'h0004);
		rd_chk(5'h07, 16'h2001);
		rd_chk(5'h08, 16'h0000);
		rd_chk(5'h0F, 16'h8000);
	endtask

	task automatic t_base();
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			page(1'b1, {c[0], 1'b1, c, 3'h7, c, c, 5'h1F});
			rd_chk(5'h05, {c[0], 1'b1, c, 3'h0, c, c, 5'h00});
			rd_chk(5'h06, 16'h0006);
			rd_chk(5'h06, 16'h0004);
		end
	endtask

	task automatic t_np();
		logic [15:0] w [2];
		w = '{16'hB5A5, 16'h4A5A};
		for (int k = 0; k < 2; k++) begin
			page(1'b0, w[k]);
			rd_chk(5'h06, 16'h0006);
			rd_chk(5'h08, w[k]);
		end
		rd_chk(5'h05, 16'hF1E0);
	endtask

	task automatic t_np_tx();
		wr(5'h07, 16'hFFFF);
		rd_chk(5'h07, 16'hB7FF);
		chk("tx word", np_word, 16'hB7FF);
		for (int k = 0; k < 3; k++) begin
			np_sent <= 1'b1;
			@(posedge clk_sys);
			np_sent <= 1'b0;
			@(posedge clk_sys);
			chk("tx toggle", np_word, (k == 1) ? 16'hB7FF : 16'hBFFF);
		end
		wr(5'h07, 16'h0000);
		rd_chk(5'h07, 16'h0800);
	endtask

	task automatic t_readonly();
		logic [4:0]  ra [5];
		logic [15:0] ex [5];
		ra = '{5'h05, 5'h06, 5'h08, 5'h0F, 5'h1F};
		ex = '{16'hF1E0, 16'h0004, 16'h4A5A, 16'h8000, 16'h0000};
		for (int k = 0; k < 5; k++) begin
			wr(ra[k], 16'hFFFF);
			rd_chk(ra[k], ex[k]);
		end
		u_mgmt_host.frame(1'b1, PHY ^ 5'h01, 5'h07, 16'hFFFF, rdata);
		u_mgmt_host.frame(1'b0, PHY ^ 5'h01, 5'h07, 16'h0000, rdata);
		chk("foreign read", rdata, 16'hFFFF);
		rd_chk(5'h07, 16'h0800);
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_defaults();
		t_base();
		t_np();
		t_np_tx();
		t_readonly();
		end_sim();
	end

	// About forty frames of some seven microseconds each should finish well inside this.
	initial begin
		#1000000;
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
